// [rtl/vsim_status_irq.sv]
// video status report, interrupt mask and pending bits on a sub-address register port
// assumes the serial control interface decodes transfers into one-cycle read and write strobes
// Notes on behaviour
// RULE1 - status bit 4 is read-only, one while input video is present.
// RULE2 - status bits 3..1 read-only copy-protection class; writes ignored.
// RULE3 - status bit 0 read-only, one once video standard is determined.
// RULE4 - standard-determined flag works only with auto-detect enabled in input format bit 4.
// RULE5 - mask bit 7 enables interrupt on genlock loss.
// RULE6 - mask bit 6 enables interrupt on input signal loss.
// RULE7 - mask bit 5 enables interrupt on new caption data; resets to zero.
// RULE8 - mask bit 4 enables interrupt on new WSS data; resets to zero.
// RULE9 - mask bit 3 enables interrupt on teletext detected; resets to zero.
// RULE10 - mask bit 2 enables interrupt when copy-protection class changes.
// RULE11 - mask bit 1 enables interrupt on successful standard detection; resets zero.
// RULE12 - mask bit 0 enables interrupt at each new field; resets to zero.
// RULE13 - each source latches pending until host writes one to it.
// RULE14 - interrupt output active while any pending bit is unmasked.
`timescale 1ns/10ps
`include "vsim_map.svh"
module vsim_status_irq
    import vsim_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // register port
    input wire vsim_byte_t regAddr,
    input wire vsim_byte_t regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output vsim_byte_t regRdData,
    // video condition inputs
    input wire logic videoPresent,
    input wire vsim_cp_t copyProtectionClass,
    input wire logic standardFound,
    input wire logic genlockLocked,
    // event inputs
    input wire logic captionDataNew,
    input wire logic wssDataNew,
    input wire logic teletextSeen,
    input wire logic fieldStart,
    // outputs
    output logic autoDetectEnable,
    output logic irqRequest
);
    logic rstMeta_q;
    logic rstSyncN;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rstMeta_q <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSyncN <= rstMeta_q;
        end
    end

    vsim_byte_t mask_q;
    vsim_byte_t mask_d;
    vsim_byte_t infmt_q;
    vsim_byte_t infmt_d;
    vsim_byte_t rdData_q;
    vsim_byte_t rdData_d;
    vsim_cp_t cpPrev_q;
    vsim_cp_t cpPrev_d;
    logic present_q;
    logic present_d;
    logic locked_q;
    logic locked_d;
    logic stdOk_q;
    logic stdOk_d;
    // first cycle after reset has no previous class to compare against
    logic armed_q;
    logic armed_d;
    vsim_byte_t statusByte;
    vsim_byte_t events;
    vsim_byte_t clearBits;
    vsim_byte_t pending;
    logic stdQualified;

    // RULE4 gate on auto-detect
    assign stdQualified = standardFound & infmt_q[`VSIM_INFMT_AUTODET];
    assign autoDetectEnable = infmt_q[`VSIM_INFMT_AUTODET];

    // RULE1 RULE2 RULE3 status image, writes never reach it
    always_comb begin
        statusByte = `VSIM_ZERO8;
        statusByte[`VSIM_ST_PRESENT] = videoPresent;
        statusByte[`VSIM_ST_CP_HI:`VSIM_ST_CP_LO] = copyProtectionClass;
        statusByte[`VSIM_ST_STDOK] = stdQualified;
    end

    // source event detection
    always_comb begin
        present_d = videoPresent;
        locked_d = genlockLocked;
        stdOk_d = stdQualified;
        cpPrev_d = copyProtectionClass;
        armed_d = 1'b1;
        events = `VSIM_ZERO8;
        // RULE5 genlock loss edge
        events[`VSIM_IRQ_GENLOCK] = locked_q & ~genlockLocked;
        // RULE6 signal loss edge
        events[`VSIM_IRQ_SIGLOSS] = present_q & ~videoPresent;
        // RULE7 caption event
        events[`VSIM_IRQ_CAPTION] = captionDataNew;
        // RULE8 wss event
        events[`VSIM_IRQ_WSS] = wssDataNew;
        // RULE9 teletext event
        events[`VSIM_IRQ_TELETEXT] = teletextSeen;
        // RULE10 class change, held off until a previous class was captured
        events[`VSIM_IRQ_CPCHG] = armed_q & (cpPrev_q != copyProtectionClass);
        // RULE11 detection success edge
        events[`VSIM_IRQ_STDOK] = ~stdOk_q & stdQualified;
        // RULE12 field start
        events[`VSIM_IRQ_FIELD] = fieldStart;
    end

    // register writes and reads
    always_comb begin
        mask_d = mask_q;
        infmt_d = infmt_q;
        clearBits = `VSIM_ZERO8;
        rdData_d = rdData_q;
        if (regWrite) begin
            unique case (regAddr)
                `VSIM_ADDR_MASK: mask_d = regWrData;
                `VSIM_ADDR_INFMT: infmt_d = regWrData;
                // RULE13 write one clears
                `VSIM_ADDR_ISTAT: clearBits = regWrData;
                default: ;
            endcase
        end
        if (regRead) begin
            unique case (regAddr)
                `VSIM_ADDR_STATUS: rdData_d = statusByte;
                `VSIM_ADDR_MASK: rdData_d = mask_q;
                `VSIM_ADDR_INFMT: rdData_d = infmt_q;
                `VSIM_ADDR_ISTAT: rdData_d = pending;
                default: rdData_d = `VSIM_ZERO8;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            mask_q <= `VSIM_MASK_RESET;
            infmt_q <= `VSIM_INFMT_RESET;
            rdData_q <= `VSIM_ZERO8;
            cpPrev_q <= `VSIM_CP_RESET;
            present_q <= 1'b0;
            locked_q <= 1'b0;
            stdOk_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            infmt_q <= infmt_d;
            rdData_q <= rdData_d;
            cpPrev_q <= cpPrev_d;
            present_q <= present_d;
            locked_q <= locked_d;
            stdOk_q <= stdOk_d;
            armed_q <= armed_d;
        end
    end

    vsim_event_latch u_latch (
        .clock(clock),
        .rstSyncN(rstSyncN),
        .eventPulse(events),
        .clearBits(clearBits),
        .pending(pending)
    );

    assign regRdData = rdData_q;
    // RULE14 masked request
    assign irqRequest = |(pending & mask_q);

    // register port requests, each taken at the edge that samples its strobe
    sequence s_status_req;
        regRead && regAddr == `VSIM_ADDR_STATUS;
    endsequence
    sequence s_pend_req;
        regRead && regAddr == `VSIM_ADDR_ISTAT;
    endsequence
    sequence s_mask_req;
        regRead && regAddr == `VSIM_ADDR_MASK;
    endsequence
    sequence s_infmt_req;
        regRead && regAddr == `VSIM_ADDR_INFMT;
    endsequence
    sequence s_status_write;
        regWrite && regAddr == `VSIM_ADDR_STATUS;
    endsequence
    sequence s_mask_write;
        regWrite && regAddr == `VSIM_ADDR_MASK;
    endsequence
    sequence s_infmt_write;
        regWrite && regAddr == `VSIM_ADDR_INFMT;
    endsequence
    sequence s_pend_clear;
        regWrite && regAddr == `VSIM_ADDR_ISTAT;
    endsequence

    a_irq_follows_mask: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE14
        $past(events & mask_q) != `VSIM_ZERO8 && !$past(regWrite) |-> irqRequest)
        else $error("unmasked event did not raise interrupt");
    a_field_raises_irq: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE12
        fieldStart && mask_q[`VSIM_IRQ_FIELD] && !regWrite |=> irqRequest)
        else $error("field start did not raise interrupt");
    a_cp_change_pend: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE10
        armed_q && copyProtectionClass != $past(copyProtectionClass) |=> pending[`VSIM_IRQ_CPCHG])
        else $error("class change not latched");
    a_genlock_loss_pend: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE5
        armed_q && $fell(genlockLocked) |=> pending[`VSIM_IRQ_GENLOCK])
        else $error("genlock loss not latched");
    a_signal_loss_pend: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE6
        armed_q && $fell(videoPresent) |=> pending[`VSIM_IRQ_SIGLOSS])
        else $error("signal loss not latched");
    a_caption_pend: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE7
        captionDataNew |=> pending[`VSIM_IRQ_CAPTION])
        else $error("caption event not latched");
    a_wss_pend: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE8
        wssDataNew |=> pending[`VSIM_IRQ_WSS])
        else $error("wss event not latched");
    a_teletext_pend: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE9
        teletextSeen |=> pending[`VSIM_IRQ_TELETEXT])
        else $error("teletext event not latched");
    a_std_gated: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE4
        regRead && regAddr == `VSIM_ADDR_STATUS && !infmt_q[`VSIM_INFMT_AUTODET] |=> !regRdData[`VSIM_ST_STDOK])
        else $error("standard flag set while auto-detect off");
    a_std_found_pend: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE11
        $rose(stdQualified) |=> pending[`VSIM_IRQ_STDOK])
        else $error("standard detection not latched");
    a_status_read: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE2
        regRead && regAddr == `VSIM_ADDR_STATUS |=> regRdData[`VSIM_ST_CP_HI:`VSIM_ST_CP_LO] == $past(copyProtectionClass)
        && regRdData[`VSIM_ST_PRESENT] == $past(videoPresent))
        else $error("status read does not show live condition");

    // read-back, write and clear paths
    a_std_read: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE3
        s_status_req |=> regRdData[`VSIM_ST_STDOK] == ($past(standardFound) && $past(autoDetectEnable)))
        else $error("standard-determined flag misreported");
    a_status_no_write: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE1
        s_status_write |=> mask_q == $past(mask_q) && infmt_q == $past(infmt_q))
        else $error("write to status register changed a register");
    a_pend_read: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE13
        s_pend_req |=> regRdData == $past(pending))
        else $error("pending read does not show latched bits");
    a_mask_read: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE5
        s_mask_req |=> regRdData == $past(mask_q))
        else $error("mask read does not show mask");
    a_infmt_read: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE4
        s_infmt_req |=> regRdData == $past(infmt_q))
        else $error("input format read does not show register");
    a_mask_write_lands: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE5
        s_mask_write |=> mask_q == $past(regWrData))
        else $error("mask write did not land");
    a_mask_reset_zero: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE7
        $rose(rstSyncN) |-> mask_q == `VSIM_MASK_RESET && infmt_q == `VSIM_INFMT_RESET)
        else $error("mask or input format not at reset value");
    a_auto_detect_out: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE4
        s_infmt_write |=> autoDetectEnable == $past(regWrData[`VSIM_INFMT_AUTODET]))
        else $error("auto-detect enable does not follow write");
    a_std_off_quiet: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE4
        !autoDetectEnable && !pending[`VSIM_IRQ_STDOK] |=> !pending[`VSIM_IRQ_STDOK])
        else $error("standard detection latched while auto-detect off");
    a_clear_lands: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE13
        s_pend_clear |=> (pending & $past(regWrData) & ~$past(events)) == `VSIM_ZERO8)
        else $error("write one did not clear pending bit");
    a_set_beats_clear: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE13
        s_pend_clear |=> (pending & $past(events)) == $past(events))
        else $error("clear won over a same-cycle event");
    a_masked_no_irq: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE14
        mask_q == `VSIM_ZERO8 |-> !irqRequest)
        else $error("interrupt raised with every source masked");

    // no pending bit sets without its own cause
    a_genlock_quiet: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE5
        !$fell(genlockLocked) && !pending[`VSIM_IRQ_GENLOCK] |=> !pending[`VSIM_IRQ_GENLOCK])
        else $error("genlock bit set without loss");
    a_loss_quiet: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE6
        !$fell(videoPresent) && !pending[`VSIM_IRQ_SIGLOSS] |=> !pending[`VSIM_IRQ_SIGLOSS])
        else $error("signal loss bit set without loss");
    a_caption_quiet: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE7
        !captionDataNew && !pending[`VSIM_IRQ_CAPTION] |=> !pending[`VSIM_IRQ_CAPTION])
        else $error("caption bit set without event");
    a_wss_quiet: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE8
        !wssDataNew && !pending[`VSIM_IRQ_WSS] |=> !pending[`VSIM_IRQ_WSS])
        else $error("wss bit set without event");
    a_teletext_quiet: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE9
        !teletextSeen && !pending[`VSIM_IRQ_TELETEXT] |=> !pending[`VSIM_IRQ_TELETEXT])
        else $error("teletext bit set without event");
    a_cp_quiet: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE10
        $stable(copyProtectionClass) && !pending[`VSIM_IRQ_CPCHG] |=> !pending[`VSIM_IRQ_CPCHG])
        else $error("class change bit set without change");
    a_std_quiet: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE11
        !$rose(stdQualified) && !pending[`VSIM_IRQ_STDOK] |=> !pending[`VSIM_IRQ_STDOK])
        else $error("standard detection bit set without detection");
    a_field_quiet: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE12
        !fieldStart && !pending[`VSIM_IRQ_FIELD] |=> !pending[`VSIM_IRQ_FIELD])
        else $error("field bit set without field start");
endmodule

// [include/vsim_map.svh]
// offsets, field positions and reset values of the video status and interrupt mask block
// assumes a byte-wide sub-address register port driven by the serial control interface
`ifndef VSIM_MAP_SVH
`define VSIM_MAP_SVH
`define VSIM_ADDR_INFMT 8'h01
`define VSIM_ADDR_STATUS 8'h0e
`define VSIM_ADDR_MASK 8'h0f
`define VSIM_ADDR_ISTAT 8'h10
`define VSIM_INFMT_AUTODET 4
`define VSIM_ST_PRESENT 4
`define VSIM_ST_CP_HI 3
`define VSIM_ST_CP_LO 1
`define VSIM_ST_STDOK 0
`define VSIM_IRQ_GENLOCK 7
`define VSIM_IRQ_SIGLOSS 6
`define VSIM_IRQ_CAPTION 5
`define VSIM_IRQ_WSS 4
`define VSIM_IRQ_TELETEXT 3
`define VSIM_IRQ_CPCHG 2
`define VSIM_IRQ_STDOK 1
`define VSIM_IRQ_FIELD 0
`define VSIM_MASK_RESET 8'h00
`define VSIM_INFMT_RESET 8'h00
`define VSIM_ISTAT_RESET 8'h00
`define VSIM_CP_RESET 3'h0
`define VSIM_ZERO8 8'h00
`endif

// [include/vsim_pkg.sv]
// types shared by the video status and interrupt mask block
// assumes nothing beyond a SystemVerilog compiler
package vsim_pkg;
    typedef logic [7:0] vsim_byte_t;
    typedef logic [2:0] vsim_cp_t;
    typedef enum logic [2:0] {
        VSIM_CP_NONE = 3'b000,
        VSIM_CP_PULSE_ONLY = 3'b001,
        VSIM_CP_PULSE_2L = 3'b010,
        VSIM_CP_PULSE_4L = 3'b011,
        VSIM_CP_RSV4 = 3'b100,
        VSIM_CP_RSV5 = 3'b101,
        VSIM_CP_STRIPE_2L = 3'b110,
        VSIM_CP_STRIPE_4L = 3'b111
    } vsim_cp_class_t;
endpackage

// [rtl/vsim_event_latch.sv]
// sticky pending bits, one per interrupt source, cleared by writing one
// assumes event pulses and clear strobes synchronous to clock
`timescale 1ns/10ps
`include "vsim_map.svh"
module vsim_event_latch
    import vsim_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstSyncN,
    // events and clears
    input wire vsim_byte_t eventPulse,
    input wire vsim_byte_t clearBits,
    // state
    output vsim_byte_t pending
);
    vsim_byte_t pending_q;
    vsim_byte_t pending_d;

    // RULE13 set beats clear
    always_comb begin
        pending_d = (pending_q & ~clearBits) | eventPulse;
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pending_q <= `VSIM_ISTAT_RESET;
        end else begin
            pending_q <= pending_d;
        end
    end

    assign pending = pending_q;

    // RULE13 hold until cleared
    a_pending_sticky: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE13
        $past(pending_q) != `VSIM_ZERO8 && $past(clearBits) == `VSIM_ZERO8 |-> (pending_q & $past(pending_q)) == $past(pending_q))
        else $error("pending bit dropped without a clear");
endmodule

// [bench/vsim_host_model.sv]
// host model of the sub-address register port, one byte per transfer
// assumes the bench calls wr and rd and drains expQ on rdCheck
`timescale 1ns/10ps
module vsim_host_model
    import vsim_pkg::*;
(
    // clock
    input wire logic clock,
    // register port
    output vsim_byte_t regAddr,
    output vsim_byte_t regWrData,
    output logic regWrite,
    output logic regRead,
    // read data settled for the bench
    output logic rdCheck
);
    vsim_byte_t expQ[$];
    logic rdSeen;
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        rdSeen = 1'b0;
        rdCheck = 1'b0;
    end
    // read data stands until the next read, so look a cycle late
    always @(posedge clock) begin
        rdSeen <= regRead;
        rdCheck <= rdSeen;
    end
    task automatic wr(input vsim_byte_t a, input vsim_byte_t d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        regWrData <= ~d;
    endtask
    task automatic rd(input vsim_byte_t a, input vsim_byte_t e);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        expQ.push_back(e);
        @(posedge clock);
        regRead <= 1'b0;
    endtask
endmodule

// [bench/video_status_irq_mask_bench.sv]
// self-checking bench of the video status and interrupt mask block
// assumes the host model drives the register port
`timescale 1ns/10ps
`include "vsim_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module video_status_irq_mask_bench
    import vsim_pkg::*;
;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    vsim_byte_t regAddr, regWrData, regRdData;
    logic regWrite, regRead, rdCheck, autoDetectEnable, irqRequest;
    logic videoPresent = 1'b1, standardFound = 1'b1, genlockLocked = 1'b1;
    logic captionDataNew = 1'b0, wssDataNew = 1'b0, teletextSeen = 1'b0, fieldStart = 1'b0;
    vsim_cp_t copyProtectionClass = 3'h3;
    logic autoDet = 1'b0;
    int num_errors = 0, compares = 0, seed = 32'h556e6c10, r;
    always #10 clock = ~clock;
    vsim_host_model host_u (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .rdCheck(rdCheck));
    vsim_status_irq dut_u (.clock(clock), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .videoPresent(videoPresent),
        .copyProtectionClass(copyProtectionClass), .standardFound(standardFound),
        .genlockLocked(genlockLocked), .captionDataNew(captionDataNew), .wssDataNew(wssDataNew),
        .teletextSeen(teletextSeen), .fieldStart(fieldStart), .autoDetectEnable(autoDetectEnable),
        .irqRequest(irqRequest));
    // oldest expected read value against the settled read data
    vsim_byte_t expRd;
    always @(negedge clock) begin
        if (rdCheck === 1'b1) begin
            if (host_u.expQ.size() == 0) `CHK(regRdData, 8'hxx)
            else begin
                expRd = host_u.expQ.pop_front();
                `CHK(regRdData, expRd)
            end
        end
    end
    function automatic vsim_byte_t stat();
        return {3'h0, videoPresent, copyProtectionClass, standardFound & autoDet};
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one event of source i, genlock, video and standard levels back to idle afterwards, the new class stays
    task automatic fire(int i);
        @(posedge clock);
        case (i)
            7: genlockLocked <= 1'b0;
            6: videoPresent <= 1'b0;
            5: captionDataNew <= 1'b1;
            4: wssDataNew <= 1'b1;
            3: teletextSeen <= 1'b1;
            2: begin r = $random(seed); copyProtectionClass <= copyProtectionClass + 3'(r[1:0]) + 3'h1; end
            1: standardFound <= 1'b0;
            default: fieldStart <= 1'b1;
        endcase
        @(posedge clock);
        {captionDataNew, wssDataNew, teletextSeen, fieldStart} <= 4'h0;
        genlockLocked <= 1'b1;
        videoPresent <= 1'b1;
        standardFound <= 1'b1;
    endtask
    initial begin
        tick(4);
        resetn <= 1'b1;
        tick(3);
        host_u.rd(`VSIM_ADDR_MASK, `VSIM_MASK_RESET);
        host_u.rd(`VSIM_ADDR_STATUS, stat());
        host_u.wr(`VSIM_ADDR_INFMT, 8'h10);
        autoDet = 1'b1;
        tick(2);
        @(negedge clock);
        `CHK(autoDetectEnable, 1'b1)
        host_u.rd(`VSIM_ADDR_STATUS, stat());
        host_u.wr(`VSIM_ADDR_STATUS, 8'hff);
        host_u.rd(`VSIM_ADDR_STATUS, stat());
        host_u.rd(8'h3c, 8'h00);
        for (int i = 0; i < 8; i++) begin
            host_u.wr(`VSIM_ADDR_ISTAT, 8'hff);
            host_u.wr(`VSIM_ADDR_MASK, 8'h01 << i);
            tick(2);
            @(negedge clock);
            `CHK(irqRequest, 1'b0)
            fire(i);
            tick(2);
            @(negedge clock);
            `CHK(irqRequest, 1'b1)
            host_u.rd(`VSIM_ADDR_STATUS, stat());
            host_u.rd(`VSIM_ADDR_ISTAT, 8'h01 << i);
            host_u.wr(`VSIM_ADDR_MASK, 8'h00);
            tick(2);
            @(negedge clock);
            `CHK(irqRequest, 1'b0)
            host_u.wr(`VSIM_ADDR_ISTAT, 8'h01 << i);
            host_u.rd(`VSIM_ADDR_ISTAT, 8'h00);
        end
        host_u.rd(`VSIM_ADDR_INFMT, 8'h10);
        // event and clear in one cycle, all sources masked: bit latches, output stays low
        host_u.wr(`VSIM_ADDR_ISTAT, 8'hff);
        fork
            host_u.wr(`VSIM_ADDR_ISTAT, 8'h01);
            fire(0);
        join
        tick(2);
        @(negedge clock);
        `CHK(irqRequest, 1'b0)
        host_u.rd(`VSIM_ADDR_ISTAT, 8'h01);
        // with auto-detect off a new standard is neither reported nor latched
        host_u.wr(`VSIM_ADDR_INFMT, 8'h00);
        autoDet = 1'b0;
        host_u.wr(`VSIM_ADDR_ISTAT, 8'hff);
        fire(1);
        tick(2);
        host_u.rd(`VSIM_ADDR_ISTAT, 8'h00);
        host_u.rd(`VSIM_ADDR_STATUS, stat());
        for (int k = 0; k < 20 && host_u.expQ.size() != 0; k++) tick(1);
        if (host_u.expQ.size() != 0) num_errors++;
        tally_and_finish();
    end
endmodule
